// *** include/kwu_pkg.sv ***
package kwu_pkg;
  // register offsets (index on the plain register port)
  localparam logic [1:0] ADDR_STATUS_CTRL = 2'h0;
  localparam logic [1:0] ADDR_PIN_ENABLE  = 2'h1;
  localparam logic [1:0] ADDR_EDGE_SELECT = 2'h2;
  // status/control field positions
  localparam int BIT_FLAG = 3;
  localparam int BIT_ACK  = 2;
  localparam int BIT_IRQE = 1;
  localparam int BIT_MODE = 0;
  // implemented pin bits 5,4,2,1,0
  localparam logic [7:0] PIN_MASK = 8'h37;
  localparam int NUM_PINS = 6;
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic       RST_BIT = 1'b0;
endpackage : kwu_pkg

// *** logic/kwu_sync.sv ***
`timescale 1ns/1ps
module kwu_sync (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // pins
  input  wire logic [5:0] pin_async,
  output logic      [5:0] pin_sync
);
  logic [5:0] meta_q;

  // two flops per pin; the first is read only by the second
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_q   <= 6'h00;
      pin_sync <= 6'h00;
    end else begin
      meta_q   <= pin_async;
      pin_sync <= meta_q;
    end
  end
endmodule : kwu_sync

// *** logic/kwu_detect.sv ***
`timescale 1ns/1ps
module kwu_detect (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // synchronised pins and configuration
  input  wire logic [5:0] pin_sync,
  input  wire logic [5:0] pin_en,
  input  wire logic [5:0] pol,
  // per-pin results
  output logic      [5:0] edge_hit,
  output logic      [5:0] level_hit
);
  logic [5:0] asserted;
  logic [5:0] prev_q;

  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_pin
      // polarity 1 means high/rising is the asserted sense
      assign asserted[i]  = pin_sync[i] ~^ pol[i];
      assign edge_hit[i]  = pin_en[i] & asserted[i] & ~prev_q[i];
      assign level_hit[i] = pin_en[i] & asserted[i];
    end
  endgenerate

  // previous-cycle sample; reset as asserted so no edge is seen right after reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prev_q <= 6'h3f;
    end else begin
      prev_q <= asserted;
    end
  end
endmodule : kwu_detect

// *** logic/kwu_top.sv ***
`timescale 1ns/1ps
// Operation
// - each pin has own enable bit
// - edge-only or edge-and-level sensitivity per mode
// - one shared source gated by interrupt enable
// - keeps detecting in wait; wakes when enabled
// - stop wake detected from the synchronised pin level, still on the clock
// - debug halt changes nothing
// - key pins are inputs only
// - status/control bit layout, ack reads zero
// - pin enable bits 5,4,2,1,0 only
// - polarity bits 5,4,2,1,0 only
// - edge is deasserted then asserted sample
// - event sets flag; irq is flag and enable
// - ack clears flag unless level still asserted; in edge-only mode ack clears it even while the level stays asserted
// - polarity and mode encodings
module kwu_top (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // key pins, inputs only
  input  wire logic [5:0] key_input_pins,
  // power and debug state
  input  wire logic       stop_mode,
  input  wire logic       debug_halt,
  // outputs to the cpu
  output logic            key_irq,
  output logic            key_wake
);
  logic [7:0] kbd_pin_enable_q;
  logic [7:0] kbd_edge_select_q;
  logic       key_irq_enable_q;
  logic       detect_mode_select_q;
  logic       key_event_flag_q;
  logic [5:0] pin_sync;
  logic [5:0] edge_hit;
  logic [5:0] level_hit;
  logic       event_now;
  logic       level_now;
  logic       ack_wr;
  logic       stop_hit;

  // debug_halt deliberately feeds nothing: the block runs on in debug
  // pins pass two flops before any logic
  kwu_sync kwu_sync_inst (
    .core_clk  (core_clk),
    .reset     (reset),
    .pin_async (key_input_pins),
    .pin_sync  (pin_sync)
  );

  kwu_detect kwu_detect_inst (
    .core_clk  (core_clk),
    .reset     (reset),
    .pin_sync  (pin_sync),
    .pin_en    (kbd_pin_enable_q[5:0]),
    .pol       (kbd_edge_select_q[5:0]),
    .edge_hit  (edge_hit),
    .level_hit (level_hit)
  );

  // an asserted level on an enabled pin counts as an event only in edge-and-level mode
  assign level_now = detect_mode_select_q & (|level_hit);
  assign event_now = (|edge_hit) | level_now;
  assign ack_wr    = reg_wr && (reg_addr == kwu_pkg::ADDR_STATUS_CTRL)
                     && reg_wdata[kwu_pkg::BIT_ACK];
  // stop detect: enabled pin at its asserted level; uses the synchronised pin so
  // no logic ever reads a raw pad, at the cost of two cycles of wake latency
  assign stop_hit  = |level_hit;

  // configuration registers; unimplemented bits never store
  always_ff @(posedge core_clk) begin
    if (reset) begin
      kbd_pin_enable_q  <= kwu_pkg::RST_REG;
      kbd_edge_select_q <= kwu_pkg::RST_REG;
    end else if (reg_wr) begin
      if (reg_addr == kwu_pkg::ADDR_PIN_ENABLE) begin
        kbd_pin_enable_q <= reg_wdata & kwu_pkg::PIN_MASK;
      end
      if (reg_addr == kwu_pkg::ADDR_EDGE_SELECT) begin
        kbd_edge_select_q <= reg_wdata & kwu_pkg::PIN_MASK;
      end
    end
  end

  // control bits of the status/control register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      key_irq_enable_q     <= kwu_pkg::RST_BIT;
      detect_mode_select_q <= kwu_pkg::RST_BIT;
    end else if (reg_wr && reg_addr == kwu_pkg::ADDR_STATUS_CTRL) begin
      key_irq_enable_q     <= reg_wdata[kwu_pkg::BIT_IRQE];
      detect_mode_select_q <= reg_wdata[kwu_pkg::BIT_MODE];
    end
  end

  // flag: a new event wins over an acknowledge in the same cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      key_event_flag_q <= kwu_pkg::RST_BIT;
    end else if (event_now) begin
      key_event_flag_q <= 1'b1;
    end else if (ack_wr) begin
      key_event_flag_q <= 1'b0;
    end
  end

  // read data one cycle after the strobe, zero otherwise; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        kwu_pkg::ADDR_STATUS_CTRL: reg_rdata <= {4'h0, key_event_flag_q, 1'b0,
                                                 key_irq_enable_q,
                                                 detect_mode_select_q};
        kwu_pkg::ADDR_PIN_ENABLE:  reg_rdata <= kbd_pin_enable_q;
        kwu_pkg::ADDR_EDGE_SELECT: reg_rdata <= kbd_edge_select_q;
        default:                   reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // single shared request; registered so it comes straight from a flop
  always_ff @(posedge core_clk) begin
    if (reset) begin
      key_irq <= 1'b0;
    end else begin
      key_irq <= (key_event_flag_q | event_now) & key_irq_enable_q
                 & ~(ack_wr & ~event_now);
    end
  end

  // wake request: in wait the clocked path wakes; in stop the synchronised pin level is used,
  // since no edge can be sampled without the clock. registered so the output is a flop;
  // a real stopped chip would need this gate ahead of the clock restart.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      key_wake <= 1'b0;
    end else begin
      key_wake <= key_irq_enable_q & (event_now | key_event_flag_q
                  | (stop_mode & stop_hit));
    end
  end

  // flag set by an event on the next edge
  flag_set_a: assert property (@(posedge core_clk) disable iff (reset)
    event_now |=> key_event_flag_q)
    else $error("flag not set after event");
  irq_gate_a: assert property (@(posedge core_clk) disable iff (reset)
    key_irq |-> $past(key_irq_enable_q))
    else $error("irq without enable");
  ack_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    (ack_wr && !event_now) |=> !key_event_flag_q)
    else $error("ack did not clear flag");
  level_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    (ack_wr && level_now) |=> key_event_flag_q)
    else $error("level lost on ack");
  pin_mask_a: assert property (@(posedge core_clk) disable iff (reset)
    (kbd_pin_enable_q & ~kwu_pkg::PIN_MASK) == 8'h00)
    else $error("unimplemented enable bit set");
  pol_mask_a: assert property (@(posedge core_clk) disable iff (reset)
    (kbd_edge_select_q & ~kwu_pkg::PIN_MASK) == 8'h00)
    else $error("unimplemented polarity bit set");
  sc_read_a: assert property (@(posedge core_clk) disable iff (reset)
    (reg_rd && reg_addr == kwu_pkg::ADDR_STATUS_CTRL) |=> (reg_rdata[7:4] == 4'h0
      && !reg_rdata[kwu_pkg::BIT_ACK]))
    else $error("status read reserved bits nonzero");
  disabled_quiet_a: assert property (@(posedge core_clk) disable iff (reset)
    (kbd_pin_enable_q == 8'h00) |-> !event_now)
    else $error("event with all pins disabled");
  edge_mode_a: assert property (@(posedge core_clk) disable iff (reset)
    (!detect_mode_select_q && event_now) |-> (|edge_hit))
    else $error("level event in edge mode");

  // request follows the flag, gated by the enable of the cycle before
  irq_track_a: assert property (@(posedge core_clk) disable iff (reset)
    key_irq == (key_event_flag_q && $past(key_irq_enable_q)))
    else $error("irq does not follow flag and enable");
  // no wake request unless the interrupt was enabled
  wake_gate_a: assert property (@(posedge core_clk) disable iff (reset)
    key_wake |-> $past(key_irq_enable_q))
    else $error("wake without enable");
  // an asserted enabled pin in stop raises wake when the interrupt is enabled
  stop_wake_a: assert property (@(posedge core_clk) disable iff (reset)
    (stop_mode && key_irq_enable_q && stop_hit) |=> key_wake)
    else $error("stop wake missing");
  // read data stands only after a read strobe
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data outside read cycle");
  // reset leaves nothing enabled and no flag
  reset_clear_a: assert property (@(posedge core_clk)
    reset |=> (kbd_pin_enable_q == 8'h00 && !key_event_flag_q && !key_irq_enable_q))
    else $error("state not cleared by reset");

  irq_seen_c:   cover property (@(posedge core_clk) disable iff (reset) key_irq);
  ack_race_c:   cover property (@(posedge core_clk) disable iff (reset) ack_wr && event_now);
  stop_wake_c:  cover property (@(posedge core_clk) disable iff (reset) stop_mode && key_wake);
  level_keep_c: cover property (@(posedge core_clk) disable iff (reset) ack_wr && level_now);
endmodule : kwu_top

// *** verif/kwu_keys_model.sv ***
`timescale 1ns/1ps
// switches to ground with pull-ups, so an open key reads high
module kwu_keys_model (
  // pins toward the block
  output logic [5:0] pins
);
  initial pins = 6'h3f;
  // called right after a clock edge, so the pin moves by nba only
  task automatic set_pin(input int n, input logic v);
    pins[n] <= v;
  endtask : set_pin
endmodule : kwu_keys_model

// *** verif/key_wake_interrupt_test.sv ***
`timescale 1ns/1ps
module key_wake_interrupt_test;
  logic       core_clk   = 1'b0;
  logic       reset      = 1'b1;
  logic [1:0] reg_addr   = 2'h0;
  logic [7:0] reg_wdata  = 8'h00;
  logic       reg_wr     = 1'b0;
  logic       reg_rd     = 1'b0;
  logic       stop_mode  = 1'b0;
  logic       debug_halt = 1'b0;
  logic [7:0] reg_rdata;
  logic [5:0] pins;
  logic       key_irq;
  logic       key_wake;
  int         err_count   = 0;
  int         comparisons = 0;

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  kwu_keys_model kwu_keys_model_inst (.pins(pins));
  kwu_top kwu_top_inst (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_input_pins(pins),
    .stop_mode(stop_mode), .debug_halt(debug_halt), .key_irq(key_irq), .key_wake(key_wake)
  );

  // compare and count
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // one-cycle write strobe
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data is only valid in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check("reg_rdata", exp, reg_rdata);
    @(posedge core_clk);
  endtask : rd

  // pins need two edges through the synchroniser, one more for the flag
  task automatic settle();
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle

  task automatic t_regs();
    for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
    wr(2'h0, 8'hff);
    rd(2'h0, 8'h03);
    wr(2'h0, 8'h04);
    wr(2'h1, 8'hff);
    rd(2'h1, 8'h37);
    wr(2'h1, 8'h00);
    wr(2'h2, 8'hff);
    rd(2'h2, 8'h37);
    wr(2'h2, 8'h00);
    wr(2'h3, 8'hff);
    rd(2'h0, 8'h00);
    $display("done t_regs");
  endtask : t_regs

  task automatic t_edge();
    wr(2'h0, 8'h02);
    kwu_keys_model_inst.set_pin(0, 1'b0);
    settle();
    check("key_irq", 8'h00, {7'h0, key_irq});
    kwu_keys_model_inst.set_pin(0, 1'b1);
    wr(2'h1, 8'h01);
    debug_halt <= 1'b1;
    settle();
    kwu_keys_model_inst.set_pin(0, 1'b0);
    settle();
    check("key_irq", 8'h01, {7'h0, key_irq});
    rd(2'h0, 8'h0a);
    wr(2'h0, 8'h06);
    rd(2'h0, 8'h02);
    kwu_keys_model_inst.set_pin(0, 1'b1);
    $display("done t_edge");
  endtask : t_edge

  task automatic t_level();
    wr(2'h0, 8'h07);
    kwu_keys_model_inst.set_pin(0, 1'b0);
    settle();
    rd(2'h0, 8'h0b);
    wr(2'h0, 8'h07);
    rd(2'h0, 8'h0b);
    kwu_keys_model_inst.set_pin(0, 1'b1);
    settle();
    wr(2'h0, 8'h07);
    rd(2'h0, 8'h03);
    $display("done t_level");
  endtask : t_level

  task automatic t_rise_stop();
    wr(2'h0, 8'h04);
    wr(2'h1, 8'h20);
    wr(2'h2, 8'h20);
    kwu_keys_model_inst.set_pin(5, 1'b0);
    settle();
    kwu_keys_model_inst.set_pin(5, 1'b1);
    settle();
    rd(2'h0, 8'h08);
    check("key_irq", 8'h00, {7'h0, key_irq});
    check("key_wake", 8'h00, {7'h0, key_wake});
    stop_mode <= 1'b1;
    wr(2'h0, 8'h06);
    settle();
    check("key_wake", 8'h01, {7'h0, key_wake});
    $display("done t_rise_stop");
  endtask : t_rise_stop

  // verdict
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // watchdog, well beyond the roughly 125 cycles the tests need
  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    wrap_up();
  end

  // reset for 8 cycles, then the scenarios
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    t_edge();
    t_level();
    t_rise_stop();
    wrap_up();
  end
endmodule : key_wake_interrupt_test
